// ==== include/host_bus_cfg_map.svh ====
/*
 * Constants for the host bus personality and card information loader.
 * Assumes inclusion by bare name from the include path.
 */
`ifndef HOST_BUS_CFG_MAP_SVH
`define HOST_BUS_CFG_MAP_SVH

// ****************************************
// I/O window and attribute space
// ****************************************
`define IO_WINDOW_BITS 4
`define CIS_BYTES 512
`define CIS_ADDR_BITS 9
`define ATTR_ADDR_BITS 16

// ****************************************
// Boot ROM window (ISA), low 20 address bits
// ****************************************
`define ROM_BASE_DEFAULT 20'hC8000
`define ROM_SIZE_BITS 14

// ****************************************
// Serial EEPROM load
// ****************************************
`define EE_CLK_DIV 4
`define ISA_CFG_BYTES 8

`endif

// ==== include/host_bus_cfg_pkg.sv ====
/*
 * Types shared by the configuration block and its EEPROM loader.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package host_bus_cfg_pkg;
	typedef enum logic [1:0] {
		PERS_ISA = 2'h0,
		PERS_CARD = 2'h1
	} personality_t;

	typedef enum logic [2:0] {
		LD_IDLE = 3'h0,
		LD_SHIFT = 3'h1,
		LD_STORE = 3'h3,
		LD_DONE = 3'h2,
		LD_NONE = 3'h6
	} load_state_t;
endpackage
`default_nettype wire

// ==== include/ee_load_if.sv ====
/*
 * Carrier between the top block and the serial EEPROM loader.
 * Assumes both ends run on ref_clk.
 */
`default_nettype none
interface ee_load_if;
	logic start;
	logic isa_mode;
	logic wr_en;
	logic [8:0] wr_addr;
	logic [7:0] wr_data;
	logic done;
	logic present;
	modport loader (input start, input isa_mode, output wr_en, output wr_addr, output wr_data,
		output done, output present);
	modport owner (output start, output isa_mode, input wr_en, input wr_addr, input wr_data,
		input done, input present);
endinterface
`default_nettype wire

// ==== design/ee_loader.sv ====
/*
 * Serial EEPROM reader: streams bytes into card information storage
 * (card mode) or configuration bytes (ISA mode) after reset.
 * Assumes the EEPROM answers on the data line each rising serial clock.
 */
`include "host_bus_cfg_map.svh"
`default_nettype none
module ee_loader
	import host_bus_cfg_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// EEPROM pins
	input wire logic ee_present,
	input wire logic ee_data_in,
	output logic ee_sclk,
	output logic ee_cs,
	// Owner side
	ee_load_if.loader ld
);
	load_state_t state, next_state;
	logic [2:0] div, next_div;
	logic [2:0] bitc, next_bitc;
	logic [7:0] sh, next_sh;
	logic [8:0] addr, next_addr;
	logic [8:0] last_addr;
	logic next_ee_cs, next_ee_sclk;

	// ISA mode only needs its config bytes; card mode fills storage
	assign last_addr = ld.isa_mode ? 9'(`ISA_CFG_BYTES - 1) : 9'(`CIS_BYTES - 1);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_state = state;
		next_div = div;
		next_bitc = bitc;
		next_sh = sh;
		next_addr = addr;
		unique case (state)
			LD_IDLE: begin
				if (ld.start) begin
					next_state = ee_present ? LD_SHIFT : LD_NONE;
				end
			end
			LD_SHIFT: begin
				next_div = div + 3'h1;
				if (div == 3'(`EE_CLK_DIV - 1)) begin
					next_div = 3'h0;
					next_sh = {sh[6:0], ee_data_in};
					next_bitc = bitc + 3'h1;
					if (bitc == 3'h7) begin
						next_state = LD_STORE;
					end
				end
			end
			LD_STORE: begin
				next_addr = addr + 9'h1;
				next_state = (addr == last_addr) ? LD_DONE : LD_SHIFT;
			end
			LD_DONE: begin
			end
			LD_NONE: begin
			end
		endcase
		// Pins follow the next state so the flops show what the state decodes to
		next_ee_cs = (next_state == LD_SHIFT) || (next_state == LD_STORE);
		next_ee_sclk = (next_state == LD_SHIFT) && next_div[1];
	end

	// Registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= LD_IDLE;
			div <= 3'h0;
			bitc <= 3'h0;
			sh <= 8'h00;
			addr <= 9'h000;
			ee_cs <= 1'b0;
			ee_sclk <= 1'b0;
		end else begin
			state <= next_state;
			div <= next_div;
			bitc <= next_bitc;
			sh <= next_sh;
			addr <= next_addr;
			ee_cs <= next_ee_cs;
			ee_sclk <= next_ee_sclk;
		end
	end

	// Outputs derived from state
	assign ld.wr_en = (state == LD_STORE);
	assign ld.wr_addr = addr;
	assign ld.wr_data = sh;
	assign ld.done = (state == LD_DONE) || (state == LD_NONE);
	assign ld.present = (state != LD_NONE);

	chk_load_ends: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == LD_DONE) |=> (state == LD_DONE))
		else $error("loader left done state");
	chk_absent_skip: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == LD_IDLE && ld.start && !ee_present) |=> (state == LD_NONE))
		else $error("absent eeprom not skipped");
	cov_full_load: cover property (@(posedge ref_clk) disable iff (!rst_n)
		ld.wr_en && addr == 9'h1FF);
endmodule
`default_nettype wire

// ==== design/host_bus_mode_and_cis_config.sv ====
/*
 * Host bus personality latch, I/O and memory space decode, interrupt merge
 * and card information storage for a combined network and modem controller.
 * Assumes host strobes and addresses are synchronous to ref_clk.
 */
// Functional notes
// - The strap is sampled at the end of power-on reset; low selects card mode, else ISA.
// - The personality is latched once and never changes until the next power-on reset.
// - In ISA mode sixteen consecutive I/O locations are claimed, all of them for the LAN function.
// - In card mode I/O decode ignores address lines A4 to A15.
// - In card mode separate decoders qualify LAN and modem I/O accesses.
// - With only one function enabled the per-function decoders are bypassed.
// - The LAN interrupt and the modem interrupt input are merged into one host request.
// - Boot ROM space answers only in ISA mode, attribute space only in card mode.
// - After reset the card information is read from the serial EEPROM into storage.
// - Storage holds 512 bytes; attribute accesses beyond go to the parallel EEPROM.
// - In card mode without a serial EEPROM the first 512 bytes also go to the parallel EEPROM.
// - In card mode I/O base and interrupt line are not taken from the serial EEPROM.
// - In ISA mode configuration and station address are loaded from the serial EEPROM.
// - In ISA mode the strap pin drives a ROM select while memory read is low on a ROM address.
`include "host_bus_cfg_map.svh"
`default_nettype none
module host_bus_mode_and_cis_config
	import host_bus_cfg_pkg::*;
#(
	parameter logic [19:0] ROM_BASE = `ROM_BASE_DEFAULT,
	parameter int CIS_DEPTH = `CIS_BYTES
) (
	// Clock and power-on reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Mode strap pin, three signals
	input wire logic mode_strap_rom_select_in,
	output logic mode_strap_rom_select_out,
	output logic mode_strap_rom_select_oe,
	// Host bus
	input wire logic [19:0] host_addr,
	input wire logic aen,
	input wire logic io_rd_n,
	input wire logic io_wr_n,
	input wire logic mem_rd_n,
	input wire logic reg_n,
	input wire logic ce1_n,
	input wire logic [15:0] io_base,
	// Function enables from the card configuration
	input wire logic lan_enable,
	input wire logic modem_enable,
	input wire logic [15:0] lan_io_base,
	input wire logic [15:0] modem_io_base,
	// Interrupts
	input wire logic lan_irq,
	input wire logic modem_irq,
	output logic host_irq,
	// Serial EEPROM
	input wire logic ee_present,
	input wire logic ee_data_in,
	output logic ee_sclk,
	output logic ee_cs,
	// Decode results
	output logic card_mode,
	output logic lan_io_sel,
	output logic modem_io_sel,
	output logic cis_sel,
	output logic par_eeprom_sel,
	output logic attr_wait,
	output logic [7:0] cis_data,
	output logic [7:0] cfg_byte0,
	output logic load_done
);
	// Storage index is fixed at nine bits, so other depths are refused
	if (CIS_DEPTH != `CIS_BYTES) begin : g_depth_check
		$error("CIS_DEPTH must match the 9-bit storage index");
	end

	ee_load_if ld();

	// ****************************************
	// Personality latch
	// ****************************************
	personality_t pers, next_pers;
	logic latched, next_latched;

	// Strap caught at the first clock after release, never under reset
	always_comb begin
		next_pers = pers;
		next_latched = 1'b1;
		if (!latched) begin
			next_pers = mode_strap_rom_select_in ? PERS_ISA : PERS_CARD;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pers <= PERS_ISA;
			latched <= 1'b0;
		end else begin
			pers <= next_pers;
			latched <= next_latched;
		end
	end

	logic is_card;
	assign is_card = latched && (pers == PERS_CARD);

	// ****************************************
	// Combinational decode
	// ****************************************
	logic io_cyc, io_hit_isa, single_fn, lan_d, modem_d, rom_hit, attr_cyc, attr_low;
	logic cis_d, par_d, wait_d, rom_cs;
	assign io_cyc = !io_rd_n || !io_wr_n;
	// ISA compares A4-A15 against the base; card mode leaves slot decode to the socket
	assign io_hit_isa = !aen && (host_addr[15:`IO_WINDOW_BITS] == io_base[15:`IO_WINDOW_BITS]);
	assign single_fn = lan_enable ^ modem_enable;
	always_comb begin
		lan_d = 1'b0;
		modem_d = 1'b0;
		if (latched && io_cyc) begin
			if (!is_card) begin
				lan_d = io_hit_isa;
			end else if (single_fn) begin
				lan_d = lan_enable;
				modem_d = modem_enable;
			end else if (lan_enable) begin
				// Low nibble only, A4-A15 are disregarded
				lan_d = host_addr[3:0] == lan_io_base[3:0];
				modem_d = host_addr[3:0] != lan_io_base[3:0] &&
					host_addr[3:0] == modem_io_base[3:0];
			end
		end
	end
	assign rom_hit = host_addr[19:`ROM_SIZE_BITS] == ROM_BASE[19:`ROM_SIZE_BITS];
	assign rom_cs = latched && !is_card && !mem_rd_n && rom_hit;
	assign attr_cyc = is_card && !reg_n && !ce1_n;
	assign attr_low = host_addr[`ATTR_ADDR_BITS-1:`CIS_ADDR_BITS] == '0;
	// Without a serial part the whole space, including the low 512 bytes, is external
	assign cis_d = attr_cyc && attr_low && ld.present && ld.done;
	assign par_d = attr_cyc && (!attr_low || !ld.present);
	assign wait_d = attr_cyc && attr_low && ld.present && !ld.done;

	// ****************************************
	// Card information and config storage
	// ****************************************
	logic [7:0] cis_mem [CIS_DEPTH];
	logic [7:0] cfg_mem [`ISA_CFG_BYTES];
	logic [7:0] next_cis_data;

	assign ld.start = latched;
	assign ld.isa_mode = !is_card;

	// Card mode writes storage only; I/O base and IRQ bytes are never taken
	always_ff @(posedge ref_clk) begin
		if (ld.wr_en && is_card) begin
			cis_mem[ld.wr_addr] <= ld.wr_data;
		end
		if (ld.wr_en && !is_card) begin
			cfg_mem[ld.wr_addr[2:0]] <= ld.wr_data;
		end
	end

	always_comb begin
		next_cis_data = cis_d ? cis_mem[host_addr[`CIS_ADDR_BITS-1:0]] : 8'h00;
	end

	// ****************************************
	// Output registers
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_strap_rom_select_out <= 1'b1;
			mode_strap_rom_select_oe <= 1'b0;
			host_irq <= 1'b0;
			card_mode <= 1'b0;
			lan_io_sel <= 1'b0;
			modem_io_sel <= 1'b0;
			cis_sel <= 1'b0;
			par_eeprom_sel <= 1'b0;
			attr_wait <= 1'b0;
			cis_data <= 8'h00;
			cfg_byte0 <= 8'h00;
			load_done <= 1'b0;
		end else begin
			mode_strap_rom_select_out <= !rom_cs;
			mode_strap_rom_select_oe <= latched && !is_card;
			host_irq <= lan_irq || modem_irq;
			card_mode <= is_card;
			lan_io_sel <= lan_d;
			modem_io_sel <= modem_d;
			cis_sel <= cis_d;
			par_eeprom_sel <= par_d;
			attr_wait <= wait_d;
			cis_data <= next_cis_data;
			cfg_byte0 <= (ld.done && !is_card) ? cfg_mem[0] : 8'h00;
			load_done <= ld.done;
		end
	end

	ee_loader u_loader (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ee_present(ee_present),
		.ee_data_in(ee_data_in),
		.ee_sclk(ee_sclk),
		.ee_cs(ee_cs),
		.ld(ld.loader)
	);

	// ****************************************
	// Checks
	// ****************************************
	chk_mode_stays: assert property (@(posedge ref_clk) disable iff (!rst_n)
		latched |=> $stable(pers))
		else $error("personality changed after latch");
	chk_strap_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!latched |=> latched && (pers == ($past(mode_strap_rom_select_in) ? PERS_ISA : PERS_CARD)))
		else $error("strap not sampled");
	chk_irq_merge: assert property (@(posedge ref_clk) disable iff (!rst_n)
		1'b1 |=> host_irq == $past(lan_irq || modem_irq))
		else $error("interrupt not merged");
	chk_isa_no_attr: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!card_mode |-> !cis_sel && !par_eeprom_sel)
		else $error("attribute space claimed in isa");
	chk_rom_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(latched && !is_card && !mem_rd_n && rom_hit) |=> !mode_strap_rom_select_out)
		else $error("rom select missing");
	chk_card_no_rom: assert property (@(posedge ref_clk) disable iff (!rst_n)
		card_mode |-> mode_strap_rom_select_out && !mode_strap_rom_select_oe)
		else $error("rom select in card mode");
	chk_hold_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cis_sel |-> load_done)
		else $error("storage read before load");
	chk_high_external: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(attr_cyc && !attr_low) |=> par_eeprom_sel && !cis_sel)
		else $error("high attribute not external");
	chk_no_serial: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(attr_cyc && ld.done && !ld.present) |=> par_eeprom_sel)
		else $error("low attribute not external");
	chk_single_fn: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(is_card && io_cyc && lan_enable && !modem_enable) |=> lan_io_sel && !modem_io_sel)
		else $error("single function bypass failed");
	cov_card_mode: cover property (@(posedge ref_clk) disable iff (!rst_n) card_mode && cis_sel);
	cov_isa_rom: cover property (@(posedge ref_clk) disable iff (!rst_n) !mode_strap_rom_select_out);
	cov_modem_io: cover property (@(posedge ref_clk) disable iff (!rst_n) modem_io_sel);
endmodule
`default_nettype wire

// ==== testbench/ser_eeprom_model.sv ====
/*
 * Serial EEPROM stand-in: shifts byte n as n ^ 5A, MSB first.
 * Assumes ee_sclk and ee_cs come from logic clocked by ref_clk.
 */
`default_nettype none
module ser_eeprom_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial pins
	input wire logic ee_cs,
	input wire logic ee_sclk,
	output logic ee_data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Bit stream
	// ****************************************
	int bit_idx;
	logic last_sclk;
	logic [7:0] cur;
	assign cur = bit_idx[10:3] ^ 8'h5A;
	// Next bit is set up while the serial clock is low, held while high
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_idx <= 0;
			last_sclk <= 1'b0;
			ee_data_in <= 1'b0;
		end else begin
			last_sclk <= ee_sclk;
			if (ee_sclk && !last_sclk && ee_cs)
				bit_idx <= bit_idx + 1;
			if (!ee_cs)
				ee_data_in <= ~ee_data_in; // Deselected: no stale bit to lean on
			else if (!ee_sclk)
				ee_data_in <= cur[7 - bit_idx[2:0]];
		end
	end
endmodule
`default_nettype wire

// ==== testbench/host_bus_mode_and_cis_config_test.sv ====
/*
 * Self-checking bench: both personalities, decode, interrupt merge, loads.
 * Assumes the serial EEPROM model and the design compile before it.
 */
`default_nettype none
module host_bus_mode_and_cis_config_test;
	timeunit 1ns;
	timeprecision 1ns;
	import host_bus_cfg_pkg::*;
	// ****************************************
	// Signals and bookkeeping
	// ****************************************
	logic ref_clk, rst_n, strap_drive, strap_out, strap_oe, strap_wire;
	logic [19:0] host_addr;
	logic aen, io_rd_n, io_wr_n, mem_rd_n, reg_n, ce1_n, lan_enable, modem_enable, lan_irq, modem_irq;
	logic [15:0] io_base, lan_io_base, modem_io_base;
	logic host_irq, ee_present, ee_data_in, ee_sclk, ee_cs, card_mode, lan_io_sel, modem_io_sel;
	logic cis_sel, par_eeprom_sel, attr_wait, load_done;
	logic [7:0] cis_data, cfg_byte0;
	int error_cnt = 0;
	int num_checks = 0;
	logic [31:0] rng = 32'd89297;
	typedef struct {int id; logic [7:0] val;} note_t;
	note_t notes[$];
	note_t cur;
	event sample_ev;
	string names[11] = '{"card_mode", "lan_io_sel", "modem_io_sel", "cis_sel", "par_eeprom_sel",
		"attr_wait", "host_irq", "rom_select", "cis_data", "cfg_byte0", "rom_select_oe"};
	// Bench strap level (strap_drive) on the strap wire unless the design drives it
	assign strap_wire = strap_oe ? strap_out : strap_drive;
	host_bus_mode_and_cis_config DUT (.ref_clk(ref_clk), .rst_n(rst_n), .mode_strap_rom_select_in(strap_wire),
		.mode_strap_rom_select_out(strap_out), .mode_strap_rom_select_oe(strap_oe), .host_addr(host_addr),
		.aen(aen), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .mem_rd_n(mem_rd_n), .reg_n(reg_n), .ce1_n(ce1_n),
		.io_base(io_base), .lan_enable(lan_enable), .modem_enable(modem_enable), .lan_io_base(lan_io_base),
		.modem_io_base(modem_io_base), .lan_irq(lan_irq), .modem_irq(modem_irq), .host_irq(host_irq),
		.ee_present(ee_present), .ee_data_in(ee_data_in), .ee_sclk(ee_sclk), .ee_cs(ee_cs),
		.card_mode(card_mode), .lan_io_sel(lan_io_sel), .modem_io_sel(modem_io_sel), .cis_sel(cis_sel),
		.par_eeprom_sel(par_eeprom_sel), .attr_wait(attr_wait), .cis_data(cis_data), .cfg_byte0(cfg_byte0),
		.load_done(load_done));
	ser_eeprom_model eeprom (.ref_clk(ref_clk), .rst_n(rst_n), .ee_cs(ee_cs), .ee_sclk(ee_sclk),
		.ee_data_in(ee_data_in));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] next_rand();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [7:0] seen(input int id);
		logic [7:0] v [11];
		v = '{{7'h0, card_mode}, {7'h0, lan_io_sel}, {7'h0, modem_io_sel}, {7'h0, cis_sel},
			{7'h0, par_eeprom_sel}, {7'h0, attr_wait}, {7'h0, host_irq}, {7'h0, strap_out}, cis_data, cfg_byte0,
			{7'h0, strap_oe}};
		return v[id];
	endfunction
	task automatic finish_test();
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic compare_flag(input int id, input logic e);
		num_checks++;
		if (seen(id) !== {7'h0, e}) begin
			$display("MISMATCH %s expected %b seen %b", names[id], e, seen(id));
			error_cnt++;
		end
	endtask
	task automatic compare_byte(input int id, input logic [7:0] e);
		num_checks++;
		if (seen(id) !== e) begin
			$display("MISMATCH %s expected %h seen %h", names[id], e, seen(id));
			error_cnt++;
		end
	endtask
	task automatic expect_out(input int id, input logic [7:0] v);
		notes.push_back('{id, v});
	endtask
	// Registered outputs settle one edge later; check at the next falling edge
	task automatic step();
		@(negedge ref_clk);
		-> sample_ev;
		#1;
	endtask
	task automatic idle();
		{aen, io_rd_n, io_wr_n, mem_rd_n, reg_n, ce1_n} = 6'b011111;
	endtask
	task automatic pwr_reset(input logic strap, input logic pres);
		rst_n = 1'b0;
		strap_drive = strap;
		ee_present = pres;
		idle();
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic wait_done();
		for (int i = 0; i < 40000 && load_done !== 1'b1; i++)
			@(negedge ref_clk);
		if (load_done !== 1'b1) begin
			error_cnt++;
			finish_test();
		end
	endtask
	// Result watcher: each sample consumes all pending notes, oldest first
	initial forever begin
		@(sample_ev);
		while (notes.size() > 0) begin
			cur = notes.pop_front();
			if (cur.id < 8 || cur.id == 10)
				compare_flag(cur.id, cur.val[0]);
			else
				compare_byte(cur.id, cur.val);
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		{host_addr, lan_enable, modem_enable, lan_irq, modem_irq} = '0;
		{io_base, lan_io_base, modem_io_base} = {16'h0300, 16'h0000, 16'h0008};
		pwr_reset(1'b1, 1'b1);
		expect_out(0, 8'h00);
		expect_out(10, 8'h01);
		step();
		strap_drive = 1'b0;
		wait_done();
		expect_out(9, 8'h5A);
		expect_out(0, 8'h00);
		step();
		// ISA window edges, then a DMA cycle that must be ignored
		for (int k = 0; k <= 17; k++) begin
			host_addr = {4'h0, io_base + 16'((k == 17) ? 0 : k)};
			{io_rd_n, io_wr_n} = k[0] ? 2'b10 : 2'b01;
			aen = (k == 17);
			expect_out(1, {7'h0, k < 16});
			step();
		end
		idle();
		host_addr = 20'(20'hC8000 + (next_rand() & 32'h3FFF));
		mem_rd_n = 1'b0;
		expect_out(7, 8'h00);
		expect_out(3, 8'h00);
		step();
		host_addr = 20'hC7FFF;
		expect_out(7, 8'h01);
		step();
		{reg_n, ce1_n, host_addr} = {2'b00, 20'h0};
		expect_out(3, 8'h00);
		step();
		idle();
		for (int i = 0; i < 4; i++) begin
			{modem_irq, lan_irq} = 2'(i);
			expect_out(6, {7'h0, i != 0});
			step();
		end
		// Card mode with serial EEPROM
		pwr_reset(1'b0, 1'b1);
		{reg_n, ce1_n, mem_rd_n, host_addr} = {3'b000, 20'h0};
		expect_out(0, 8'h01);
		expect_out(10, 8'h00);
		expect_out(5, 8'h01);
		expect_out(3, 8'h00);
		step();
		strap_drive = 1'b1;
		wait_done();
		expect_out(0, 8'h01);
		step();
		for (int j = 0; j < 5; j++) begin
			host_addr = (j == 0) ? 20'h0 : (j == 1) ? 20'h1FF : (j == 4) ? 20'h200 : 20'(next_rand() & 32'h1FF);
			expect_out(3, {7'h0, j != 4});
			expect_out(4, {7'h0, j == 4});
			expect_out(5, 8'h00);
			if (j != 4)
				expect_out(8, host_addr[7:0] ^ 8'h5A);
			step();
		end
		{reg_n, host_addr} = {1'b1, 20'hC8000};
		expect_out(3, 8'h00);
		expect_out(4, 8'h00);
		expect_out(7, 8'h01);
		step();
		idle();
		{io_rd_n, ce1_n} = 2'b00;
		// Lan only, both (nibble 0 then 8), then modem only
		for (int j = 0; j < 4; j++) begin
			lan_enable = (j != 3);
			modem_enable = (j != 0);
			host_addr = (20'(next_rand()) & 20'hFFFF0) | ((j == 2) ? 20'h8 : (j == 0) ? 20'h3 : 20'h0);
			expect_out(1, {7'h0, j < 2});
			expect_out(2, {7'h0, j >= 2});
			step();
		end
		// Card mode, no serial part: parallel EEPROM holds everything
		pwr_reset(1'b0, 1'b0);
		wait_done();
		{reg_n, ce1_n, mem_rd_n, host_addr} = {3'b000, 20'h10};
		expect_out(4, 8'h01);
		expect_out(3, 8'h00);
		step();
		finish_test();
	end
endmodule
`default_nettype wire
